// >>> logic/cied_defs.vh
/*
  Constants for the interrupt and exception drain unit: register
  offsets, field positions, reset values and fixed figures.
  Assumes inclusion by name from the design file.
*/
`ifndef CIED_DEFS_VH
`define CIED_DEFS_VH

// Register offsets (byte addresses)
`define CIED_OFF_TASK_STATE 8'h00
`define CIED_OFF_SAVED_TASK 8'h04
`define CIED_OFF_RET_PTR 8'h08
`define CIED_OFF_SVC_TABLE 8'h0c
`define CIED_OFF_CAUSE 8'h10
`define CIED_OFF_FLAG 8'h14
`define CIED_OFF_CLEAR 8'h18
`define CIED_OFF_IRQ_STAT 8'h1c
`define CIED_OFF_IRQ_CLR 8'h20
`define CIED_OFF_IRQ_EN 8'h24
`define CIED_OFF_STATUS 8'h28

// Task state fields
`define CIED_TS_GEE 0
`define CIED_TS_INT 1
`define CIED_TS_LOOP_EXECUTING_FLAG 2
`define CIED_TS_IB 3
`define CIED_TS_CXM_LO 6
`define CIED_TS_CXM_HI 7

// Cause and flag fields
`define CIED_CAUSE_RCX 7
`define CIED_FLAG_IXF 1
`define CIED_CLR_IXF_VAL 32'h0000_0002

// Fetch packet mask for service table match
`define CIED_SVC_MASK 32'hffff_fe1f

// Reset values
`define CIED_TS_RST 8'h00
`define CIED_PTR_RST 32'h0000_0000

// Drain counter load, stages before the first execute phase; annul holds for one cycle more than this
`define CIED_DRAIN_CYC 3'd3
// Least packets between loop end and next loop start
`define CIED_LOOP_GAP 2'd2

// Interrupt status bits
`define CIED_EV_EXC 0
`define CIED_EV_HANDLER 1
`define CIED_EV_LOOP 2

`endif

// >>> logic/cied_exc_unit.v
/*
  Interrupt context switch drain and exception unit of the core.
  Assumes pipeline status inputs are on mclk; irq_req is a pin-level
  request and is synchronised here.
*/
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "cied_defs.vh"

// Contract
// - Exceptions taken only when global exception enable is set.
// - Drain annuls instructions before first execute; annulled ones write nothing.
// - No conflict exception for annulled decode and dispatch packets.
// - Different-delay writes to one register same cycle raise conflict exception.
// - Exception seen during drain starts only at handler entry.
// - Saved task state shows interrupt one, loop zero, block zero, mode zero.
// - Saved return pointer matches service table pointer under the mask.
// - Conflict exception sets cause bit and internal exception flag.
// - Writing two to clear register clears internal flag and whole cause register.
// - Branch to saved return pointer resumes the handler normally.
// - Interrupted back-to-back loops resume, never hang, never end early.
module cied_exc_unit (
  // Clock and reset
  input wire mclk,
  input wire arst_n,
  // Register port
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata_q,
  // Interrupt request pin
  input wire irq_req,
  // Pipeline write ports in the first execute phase
  input wire wr_a_valid,
  input wire [4:0] wr_a_reg,
  input wire [1:0] wr_a_delay,
  input wire wr_b_valid,
  input wire [4:0] wr_b_reg,
  input wire [1:0] wr_b_delay,
  // Instruction flow
  input wire [31:0] cur_pc,
  input wire loop_body_end_marker,
  input wire pipelined_loop_start,
  input wire packet_issue,
  input wire ret_branch,
  // Pipeline control
  output reg annul_q,
  output reg wb_enable_q,
  output reg redirect_q,
  output reg [31:0] redirect_pc_q,
  output reg loop_hold_q,
  // Interrupt to system
  output reg irq_q
);

  localparam ST_RUN = 2'd0;
  localparam ST_DRAIN = 2'd1;
  localparam ST_HANDLER = 2'd2;
  localparam ST_EXC = 2'd3;

  reg [1:0] state_q;
  reg [2:0] drain_cnt_q;
  reg [7:0] task_state_reg_q;
  reg [7:0] saved_task_state_reg_q;
  reg [31:0] exception_return_pointer_q;
  reg [31:0] service_table_pointer_q;
  reg [31:0] internal_exception_cause_reg_q;
  reg [31:0] exception_flag_reg_q;
  reg pend_exc_q;
  reg [2:0] ev_stat_q;
  reg [2:0] ev_en_q;
  reg irq_s1_q;
  reg irq_s2_q;
  reg loop_active_q;
  reg loop_intr_q;
  reg [1:0] gap_cnt_q;
  reg [31:0] loop_pc_q;

  wire global_exception_enable = task_state_reg_q[`CIED_TS_GEE];
  wire draining = (state_q == ST_DRAIN);
  // Both write ports carry a real write
  wire both_valid = wr_a_valid && wr_b_valid;
  // Same destination register
  wire same_dest = (wr_a_reg == wr_b_reg);
  // Different delay-slot counts
  wire delay_differ = (wr_a_delay != wr_b_delay);
  // genuine conflict check on real writes
  wire conflict = both_valid && same_dest && delay_differ;
  // only first execute writes count, drain or not
  // Annulled packets never reach these ports, so no drain gating
  wire real_conflict = conflict;
  wire exc_evt = real_conflict && global_exception_enable;
  wire clr_ixf = reg_wr && (reg_addr == `CIED_OFF_CLEAR) && (reg_wdata == `CIED_CLR_IXF_VAL);
  wire svc_pc = (cur_pc & `CIED_SVC_MASK) == (service_table_pointer_q & `CIED_SVC_MASK);
  wire [2:0] ev_set;

  assign ev_set[`CIED_EV_EXC] = exc_evt;
  assign ev_set[`CIED_EV_HANDLER] = draining && (drain_cnt_q == 3'd0);
  assign ev_set[`CIED_EV_LOOP] = irq_s2_q && loop_active_q && (state_q == ST_RUN);

  // Synchroniser for interrupt pin
  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      irq_s1_q <= 1'b0;
      irq_s2_q <= 1'b0;
    end
    else
    begin
      irq_s1_q <= irq_req;
      irq_s2_q <= irq_s1_q;
    end
  end

  // Context switch state machine
  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q <= ST_RUN;
      drain_cnt_q <= 3'd0;
      annul_q <= 1'b0;
      wb_enable_q <= 1'b1;
      redirect_q <= 1'b0;
      redirect_pc_q <= `CIED_PTR_RST;
      pend_exc_q <= 1'b0;
      saved_task_state_reg_q <= `CIED_TS_RST;
      exception_return_pointer_q <= `CIED_PTR_RST;
    end
    else
    begin
      redirect_q <= 1'b0;
      case (state_q)
        ST_RUN:
        begin
          if (exc_evt)
          begin
            saved_task_state_reg_q <= task_state_reg_q;
            exception_return_pointer_q <= cur_pc;
            state_q <= ST_EXC;
          end
          else if (irq_s2_q)
          begin
            // annul packets short of the first execute phase
            annul_q <= 1'b1;
            wb_enable_q <= 1'b0;
            drain_cnt_q <= `CIED_DRAIN_CYC;
            state_q <= ST_DRAIN;
          end
        end
        ST_DRAIN:
        begin
          // hold the exception until the handler is reached
          if (exc_evt)
            pend_exc_q <= 1'b1;
          // Leave the drain once the pipeline is empty
          if (drain_cnt_q == 3'd0)
          begin
            annul_q <= 1'b0;
            wb_enable_q <= 1'b1;
            redirect_q <= 1'b1;
            redirect_pc_q <= service_table_pointer_q;
            state_q <= ST_HANDLER;
          end
          else
            drain_cnt_q <= drain_cnt_q - 3'd1;
        end
        ST_HANDLER:
        begin
          // deferred exception starts at handler entry
          if (pend_exc_q || exc_evt)
          begin
            pend_exc_q <= 1'b0;
            saved_task_state_reg_q <= {2'b00, 2'b00, 1'b0, 1'b0, 1'b1, global_exception_enable};
            // return pointer is the service fetch packet
            exception_return_pointer_q <= svc_pc ? cur_pc : service_table_pointer_q;
            state_q <= ST_EXC;
          end
          else if (ret_branch)
            state_q <= ST_RUN;
        end
        ST_EXC:
        begin
          // branch back resumes the interrupted handler if the saved interrupt bit is set, else returns to run
          if (ret_branch)
          begin
            redirect_q <= 1'b1;
            redirect_pc_q <= exception_return_pointer_q;
            state_q <= saved_task_state_reg_q[`CIED_TS_INT] ? ST_HANDLER : ST_RUN;
          end
        end
        default:
          state_q <= ST_RUN;
      endcase
    end
  end

  // Software pipelined loop tracking
  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      loop_active_q <= 1'b0;
      loop_intr_q <= 1'b0;
      gap_cnt_q <= 2'd0;
      loop_pc_q <= `CIED_PTR_RST;
      loop_hold_q <= 1'b0;
    end
    else
    begin
      if (pipelined_loop_start && !loop_intr_q)
      begin
        loop_active_q <= 1'b1;
        loop_pc_q <= cur_pc;
      end
      if (loop_body_end_marker)
        gap_cnt_q <= 2'd0;
      else if (packet_issue && gap_cnt_q != `CIED_LOOP_GAP)
        gap_cnt_q <= gap_cnt_q + 2'd1;
      // remember an interrupted loop so the next start waits
      if (loop_active_q && draining)
        loop_intr_q <= 1'b1;
      else if (state_q == ST_RUN && loop_intr_q && packet_issue
        && gap_cnt_q == `CIED_LOOP_GAP)
      begin
        loop_intr_q <= 1'b0;
        loop_active_q <= 1'b0;
      end
      // hold the next loop start until the first one resumes
      loop_hold_q <= loop_intr_q && (gap_cnt_q != `CIED_LOOP_GAP || state_q != ST_RUN);
    end
  end

  // Registers, cause and flags
  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      task_state_reg_q <= `CIED_TS_RST;
      service_table_pointer_q <= `CIED_PTR_RST;
      internal_exception_cause_reg_q <= 32'h0000_0000;
      exception_flag_reg_q <= 32'h0000_0000;
      ev_stat_q <= 3'h0;
      ev_en_q <= 3'h0;
      irq_q <= 1'b0;
    end
    else
    begin
      if (reg_wr && reg_addr == `CIED_OFF_TASK_STATE)
        task_state_reg_q <= reg_wdata[7:0];
      if (reg_wr && reg_addr == `CIED_OFF_SVC_TABLE)
        service_table_pointer_q <= reg_wdata;
      if (reg_wr && reg_addr == `CIED_OFF_IRQ_EN)
        ev_en_q <= reg_wdata[2:0];
      if (exc_evt)
        internal_exception_cause_reg_q[`CIED_CAUSE_RCX] <= 1'b1;
      else if (clr_ixf)
        internal_exception_cause_reg_q <= 32'h0000_0000;
      // clear only the internal flag, set wins
      if (exc_evt)
        exception_flag_reg_q[`CIED_FLAG_IXF] <= 1'b1;
      else if (clr_ixf)
        exception_flag_reg_q[`CIED_FLAG_IXF] <= 1'b0;
      // Event status, write one to clear, set wins
      if (reg_wr && reg_addr == `CIED_OFF_IRQ_CLR)
        ev_stat_q <= (ev_stat_q & ~reg_wdata[2:0]) | ev_set;
      else
        ev_stat_q <= ev_stat_q | ev_set;
      // Level interrupt from enabled status bits
      irq_q <= |(ev_stat_q & ev_en_q);
    end
  end

  // Read data, one cycle after the strobe
  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      reg_rdata_q <= 32'h0000_0000;
    else if (reg_rd)
    begin
      case (reg_addr)
        `CIED_OFF_TASK_STATE: reg_rdata_q <= {24'h000000, task_state_reg_q};
        `CIED_OFF_SAVED_TASK: reg_rdata_q <= {24'h000000, saved_task_state_reg_q};
        `CIED_OFF_RET_PTR: reg_rdata_q <= exception_return_pointer_q;
        `CIED_OFF_SVC_TABLE: reg_rdata_q <= service_table_pointer_q;
        `CIED_OFF_CAUSE: reg_rdata_q <= internal_exception_cause_reg_q;
        `CIED_OFF_FLAG: reg_rdata_q <= exception_flag_reg_q;
        `CIED_OFF_IRQ_STAT: reg_rdata_q <= {29'h0, ev_stat_q};
        `CIED_OFF_IRQ_EN: reg_rdata_q <= {29'h0, ev_en_q};
        `CIED_OFF_STATUS: reg_rdata_q <= {27'h0, loop_intr_q, pend_exc_q, annul_q, state_q};
        default: reg_rdata_q <= 32'h0000_0000;
      endcase
    end
    else
      reg_rdata_q <= 32'h0000_0000;
  end

endmodule

// >>> test/cied_exc_unit_bench.sv
/* Bench for the exception unit: bus, conflict, drain and loop cases.
   Assumes design and checker are compiled first. */
`timescale 1ns/1ps
`include "cied_defs.vh"
module cied_exc_unit_bench;
  reg mclk = 1'b0;
  reg arst_n = 1'b0;
  reg [7:0] reg_addr = 8'h0;
  reg [31:0] reg_wdata = 32'h0;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg irq_req = 1'b0;
  reg wr_a_valid = 1'b0;
  reg wr_b_valid = 1'b0;
  reg [4:0] wr_a_reg = 5'h0;
  reg [4:0] wr_b_reg = 5'h0;
  reg [1:0] wr_a_delay = 2'h0;
  reg [1:0] wr_b_delay = 2'h0;
  reg [31:0] cur_pc = 32'h0;
  reg [3:0] ev = 4'h0;
  wire packet_issue = ev[0];
  wire loop_body_end_marker = ev[1];
  wire pipelined_loop_start = ev[2];
  wire ret_branch = ev[3];
  wire [31:0] reg_rdata_q;
  wire [31:0] redirect_pc_q;
  wire annul_q;
  wire wb_enable_q;
  wire redirect_q;
  wire loop_hold_q;
  wire irq_q;
  integer err_total = 0;
  integer tests_run = 0;
  reg [31:0] svc;
  reg [4:0] r;
  reg rd_seen = 1'b0;
  reg [31:0] exp_q[$];
  reg [31:0] msk_q[$];
  reg [31:0] pc_q[$];
  cied_exc_unit cied_exc_unit_i (.*);
  initial
  begin
    forever #5 mclk = ~mclk;
  end
  task cmp_word(input string nm, input [31:0] e, input [31:0] g, input [31:0] m);
    begin
      tests_run = tests_run + 1;
      if ((g & m) !== (e & m))
      begin
        err_total = err_total + 1;
        $display("[FAIL] %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task cmp_bit(input string nm, input e, input g);
    begin
      tests_run = tests_run + 1;
      if (g !== e)
      begin
        err_total = err_total + 1;
        $display("[FAIL] %0s exp %b got %b", nm, e, g);
      end
    end
  endtask
  task bus(input [7:0] a, input [31:0] d, input w);
    begin
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= w;
      reg_rd <= !w;
      @(posedge mclk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [31:0] e, input [31:0] m);
    begin
      exp_q.push_back(e);
      msk_q.push_back(m);
      bus(a, 32'h0, 1'b0);
    end
  endtask
  task pulse(input [3:0] v);
    begin
      @(posedge mclk);
      ev <= v;
      cur_pc <= $urandom;
      @(posedge mclk);
      ev <= 4'h0;
    end
  endtask
  task conflict(input [1:0] db);
    begin
      @(posedge mclk);
      r = $urandom;
      {wr_a_valid, wr_b_valid, wr_a_reg, wr_b_reg} <= {2'b11, r, r};
      {wr_a_delay, wr_b_delay} <= {2'd1, db};
      @(posedge mclk);
      {wr_a_valid, wr_b_valid} <= 2'b00;
    end
  endtask
  task wait_on(input integer s);
    integer n;
    begin
      n = 0;
      #1;
      while (n < 40 && !(s == 0 ? annul_q : s == 1 ? redirect_q : !loop_hold_q))
      begin
        @(posedge mclk);
        #1;
        n = n + 1;
      end
      cmp_bit("wait", 1'b1, n < 40);
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  always @(posedge mclk)
    rd_seen <= reg_rd;
  always @(negedge mclk)
  begin
    if (rd_seen)
      cmp_word("rdata", exp_q.pop_front(), reg_rdata_q, msk_q.pop_front());
    if (redirect_q && pc_q.size() > 0)
      cmp_word("target", pc_q.pop_front(), redirect_pc_q, `CIED_SVC_MASK);
  end
  initial
  begin
    #100000;
    err_total = err_total + 1;
    give_verdict;
  end
  initial
  begin
    svc = $urandom(32'h5cde0dc5);
    repeat (5) @(posedge mclk);
    arst_n <= 1'b1;
    bus(`CIED_OFF_FLAG, 32'hffff_ffff, 1'b1);
    rd(`CIED_OFF_FLAG, 32'h0, 32'hffff_ffff);
    rd(8'h3c, 32'h0, 32'hffff_ffff);
    conflict(2'd2);
    rd(`CIED_OFF_FLAG, 32'h0, 32'hffff_ffff);
    bus(`CIED_OFF_TASK_STATE, 32'h1, 1'b1);
    bus(`CIED_OFF_IRQ_EN, 32'h7, 1'b1);
    conflict(2'd1);
    rd(`CIED_OFF_FLAG, 32'h0, 32'hffff_ffff);
    conflict(2'd3);
    rd(`CIED_OFF_FLAG, 32'h2, 32'hffff_ffff);
    rd(`CIED_OFF_CAUSE, 32'h80, 32'hffff_ffff);
    cmp_bit("irq", 1'b1, irq_q);
    bus(`CIED_OFF_IRQ_EN, 32'h0, 1'b1);
    repeat (2) @(posedge mclk);
    cmp_bit("irq", 1'b0, irq_q);
    bus(`CIED_OFF_CLEAR, 32'h1, 1'b1);
    rd(`CIED_OFF_FLAG, 32'h2, 32'hffff_ffff);
    bus(`CIED_OFF_CLEAR, 32'h2, 1'b1);
    rd(`CIED_OFF_FLAG, 32'h0, 32'hffff_ffff);
    bus(`CIED_OFF_IRQ_CLR, 32'h7, 1'b1);
    bus(`CIED_OFF_IRQ_EN, 32'h7, 1'b1);
    repeat (2) @(posedge mclk);
    cmp_bit("irq", 1'b0, irq_q);
    pc_q.push_back(32'h0);
    pulse(4'b1000);
    bus(`CIED_OFF_SVC_TABLE, svc, 1'b1);
    pc_q.push_back(svc);
    irq_req <= 1'b1;
    wait_on(0);
    conflict(2'd1);
    wait_on(1);
    irq_req <= 1'b0;
    rd(`CIED_OFF_FLAG, 32'h0, 32'hffff_ffff);
    pulse(4'b1000);
    rd(`CIED_OFF_IRQ_STAT, 32'h2, 32'h2);
    pc_q.push_back(svc);
    irq_req <= 1'b1;
    wait_on(0);
    conflict(2'd3);
    wait_on(1);
    irq_req <= 1'b0;
    rd(`CIED_OFF_SAVED_TASK, 32'h2, 32'hce);
    rd(`CIED_OFF_RET_PTR, svc, `CIED_SVC_MASK);
    rd(`CIED_OFF_FLAG, 32'h2, 32'hffff_ffff);
    bus(`CIED_OFF_CLEAR, 32'h2, 1'b1);
    rd(`CIED_OFF_FLAG, 32'h0, 32'hffff_ffff);
    pc_q.push_back(svc);
    pulse(4'b1000);
    pulse(4'b1000);
    pc_q.push_back(svc);
    pulse(4'b0101);
    irq_req <= 1'b1;
    pulse(4'b0011);
    pulse(4'b0101);
    wait_on(1);
    irq_req <= 1'b0;
    pulse(4'b1000);
    pulse(4'b0001);
    pulse(4'b0001);
    wait_on(2);
    rd(`CIED_OFF_IRQ_STAT, 32'h4, 32'h4);
    rd(`CIED_OFF_STATUS, 32'h0, 32'h1c);
    repeat (3) @(posedge mclk);
    give_verdict;
  end
endmodule

// >>> test/cied_exc_unit_monitor.sv
/* Port checker for the exception unit.
   Assumes it is bound to cied_exc_unit. */
`timescale 1ns/1ps
`include "cied_defs.vh"
module cied_exc_monitor (
  // Clock and reset
  input wire mclk,
  input wire arst_n,
  // Register port
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_rdata_q,
  // Pipeline
  input wire irq_req,
  input wire wr_a_valid,
  input wire [4:0] wr_a_reg,
  input wire [1:0] wr_a_delay,
  input wire wr_b_valid,
  input wire [4:0] wr_b_reg,
  input wire [1:0] wr_b_delay,
  input wire annul_q,
  input wire wb_enable_q,
  input wire redirect_q,
  input wire [31:0] redirect_pc_q,
  input wire loop_hold_q
);
  reg gee_q;
  reg exc_q;
  reg [31:0] svc_q;
  wire conf = wr_a_valid && wr_b_valid && wr_a_reg == wr_b_reg
    && wr_a_delay != wr_b_delay && gee_q;
  wire clr = reg_wr && reg_addr == `CIED_OFF_CLEAR && reg_wdata == `CIED_CLR_IXF_VAL;
  // Expected flag model
  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      gee_q <= 1'b0;
      exc_q <= 1'b0;
      svc_q <= 32'h0;
    end
    else
    begin
      if (reg_wr && reg_addr == `CIED_OFF_TASK_STATE)
        gee_q <= reg_wdata[0];
      if (reg_wr && reg_addr == `CIED_OFF_SVC_TABLE)
        svc_q <= reg_wdata;
      exc_q <= conf || (exc_q && !clr);
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  sequence drain_s;
    annul_q [*4];
  endsequence
  sequence resume_s;
    !annul_q && redirect_q;
  endsequence
  drain_len_a: assert property ($rose(annul_q) |-> drain_s ##1 resume_s)
    else $error("drain length wrong");
  annul_wb_a: assert property (annul_q |-> !wb_enable_q)
    else $error("write back during drain");
  annul_cause_a: assert property ($rose(annul_q) |-> $past(irq_req, 2))
    else $error("drain without request");
  redirect_pulse_a: assert property (redirect_q |=> !redirect_q)
    else $error("redirect too long");
  redirect_pc_a: assert property (redirect_q && $past(annul_q) |->
    ((redirect_pc_q ^ svc_q) & `CIED_SVC_MASK) == 32'h0)
    else $error("handler target wrong");
  flag_track_a: assert property (reg_rd && reg_addr == `CIED_OFF_FLAG |=>
    reg_rdata_q == ({31'h0, $past(exc_q)} << `CIED_FLAG_IXF))
    else $error("flag register wrong");
  cause_track_a: assert property (reg_rd && reg_addr == `CIED_OFF_CAUSE |=>
    reg_rdata_q == ({31'h0, $past(exc_q)} << `CIED_CAUSE_RCX))
    else $error("cause register wrong");
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata_q == 32'h0)
    else $error("read data not idle");
  loop_free_a: assert property (loop_hold_q |-> ##[1:64] !loop_hold_q)
    else $error("loop start held too long");
endmodule
bind cied_exc_unit cied_exc_monitor cied_exc_monitor_i (.*);
